/* ide_cs_defs.vh */
// Purpose: Offsets, field positions, reset values and bus constants of the drive chip-select block.
// Assumes: AXI4-Lite word-per-register map; printed offsets are register indices.
// Notes:   Header holds definitions only.
`ifndef IDE_CS_DEFS_VH
`define IDE_CS_DEFS_VH

// Printed indices; the byte address is the window base plus four times the index.
`define IDX_SEL_A        8'hF0
`define IDX_SEL_B        8'hF1
`define IDX_SEC_MODE     8'hF0
// Window bases: two separate the logical devices that share index 0xF0, the third holds the control words.
`define WIN_PRIMARY      12'h000
`define WIN_SECONDARY    12'h400
`define WIN_CONTROL      12'h800
// Control, status and base register words in the control window.
`define IDX_CTRL         8'h00
`define IDX_STATUS       8'h01
`define IDX_BASE_A       8'h02
`define IDX_BASE_B       8'h03

`define MASK_LSB         2
`define MASK_MSB         4
`define QUAL_LSB         0
`define QUAL_MSB         1
`define SEC_SHARE_BIT    0
`define CTRL_SOFT_RST    0

`define RST_SEL_A        8'h0C
`define RST_SEL_B        8'h00
`define RST_SEC_MODE     8'h00
`define RST_BASE         16'h0000

`define QUAL_AEN         2'b00
`define QUAL_RD          2'b01
`define QUAL_WR          2'b10
`define QUAL_RDWR        2'b11

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

/* ide_chip_select_decode.v */
// Purpose: Chip-select decoders for the primary drive port and buffer-enable steering for both drive ports.
// Assumes: ISA strobes arrive asynchronously and are synchronised here; AXI4-Lite registers.
// Notes:   Outputs are registered, so selects lag the ISA pins by three aclk edges.
`timescale 1ns/1ns
`include "ide_cs_defs.vh"

module ide_chip_select_decode #(
    parameter ADDR_W = 16
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [11:0]       s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [11:0]       s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [ADDR_W-1:0] isa_addr,
    input  wire              isa_aen,
    input  wire              isa_ior_n,
    input  wire              isa_iow_n,
    input  wire              primary_port_active,
    input  wire              secondary_port_active,
    output wire              primary_select_a_n,
    output wire              primary_select_b_n,
    output wire              primary_buffer_enable_n,
    output wire              secondary_buffer_enable_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function [ADDR_W-1:0] low_mask;
        input [2:0] code;
        begin
            case (code)
                3'd0:    low_mask = {ADDR_W{1'b0}};
                3'd1:    low_mask = {{(ADDR_W-1){1'b0}}, 1'b1};
                3'd2:    low_mask = {{(ADDR_W-2){1'b0}}, 2'b11};
                3'd3:    low_mask = {{(ADDR_W-3){1'b0}}, 3'b111};
                3'd4:    low_mask = {{(ADDR_W-4){1'b0}}, 4'hF};
                default: low_mask = {{(ADDR_W-5){1'b0}}, 5'h1F};
            endcase
        end
    endfunction

    // Returns one when the address falls in the window and the strobes qualify it.
    function sel_hit;
        input [7:0]        cfg;
        input [ADDR_W-1:0] base;
        input [ADDR_W-1:0] addr;
        input              aen;
        input              rd;
        input              wr;
        reg   [ADDR_W-1:0] m;
        reg                q;
        begin
            m = ~low_mask(cfg[`MASK_MSB:`MASK_LSB]);
            case (cfg[`QUAL_MSB:`QUAL_LSB])
                `QUAL_AEN: q = 1'b1;
                `QUAL_RD:  q = rd;
                `QUAL_WR:  q = wr;
                default:   q = rd | wr;
            endcase
            // masked compare; reserved codes never select.
            sel_hit = ((addr & m) == (base & m)) && !aen && q
                      && (cfg[`MASK_MSB:`MASK_LSB] < 3'd6);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    reg [7:0]        sel_a_ff;
    reg [7:0]        sel_b_ff;
    reg [7:0]        sec_mode_ff;
    reg [ADDR_W-1:0] base_a_ff;
    reg [ADDR_W-1:0] base_b_ff;
    reg              soft_rst_ff;

    reg              awready_ff;
    reg              wready_ff;
    reg              bvalid_ff;
    reg [1:0]        bresp_ff;
    reg              arready_ff;
    reg              rvalid_ff;
    reg [31:0]       rdata_ff;
    reg [1:0]        rresp_ff;
    reg [11:0]       awaddr_ff;
    reg              aw_held_ff;
    reg [31:0]       wdata_ff;
    reg [3:0]        wstrb_ff;
    reg              w_held_ff;

    reg [ADDR_W-1:0] addr_s1_ff;
    reg [ADDR_W-1:0] addr_s2_ff;
    reg [2:0]        ctl_s1_ff;
    reg [2:0]        ctl_s2_ff;
    reg              cs_a_n_ff;
    reg              cs_b_n_ff;
    reg              pri_oe_n_ff;
    reg              sec_oe_n_ff;

    wire aw_take  = s_axi_awvalid && awready_ff;
    wire w_take   = s_axi_wvalid && wready_ff;
    wire have_aw  = aw_held_ff || aw_take;
    wire have_w   = w_held_ff || w_take;
    wire do_write = have_aw && have_w && !bvalid_ff;

    wire [11:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;

    // Registers are reached by index; the window picks the logical device.
    function [2:0] reg_sel;
        input [11:0] a;
        reg   [11:0] win;
        reg   [7:0]  idx;
        begin
            win = a & 12'hC00;
            idx = a[9:2];
            if (a[1:0] != 2'b00)
                reg_sel = 3'd0;
            else if (win == `WIN_PRIMARY && idx == `IDX_SEL_A)
                reg_sel = 3'd1;
            else if (win == `WIN_PRIMARY && idx == `IDX_SEL_B)
                reg_sel = 3'd2;
            else if (win == `WIN_SECONDARY && idx == `IDX_SEC_MODE)
                reg_sel = 3'd3;
            else if (win == `WIN_CONTROL && idx == `IDX_CTRL)
                reg_sel = 3'd4;
            else if (win == `WIN_CONTROL && idx == `IDX_STATUS)
                reg_sel = 3'd5;
            else if (win == `WIN_CONTROL && idx == `IDX_BASE_A)
                reg_sel = 3'd6;
            else if (win == `WIN_CONTROL && idx == `IDX_BASE_B)
                reg_sel = 3'd7;
            else
                reg_sel = 3'd0;
        end
    endfunction

    wire [2:0] wsel = reg_sel(wr_addr);
    wire [2:0] rsel = reg_sel(s_axi_araddr);
    wire       soft_rst_req = do_write && wsel == 3'd4 && wr_strb[0]
                              && wr_data[`CTRL_SOFT_RST];

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel and configuration registers.

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            awaddr_ff   <= 12'h000;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= `RESP_OKAY;
            sel_a_ff    <= `RST_SEL_A;
            sel_b_ff    <= `RST_SEL_B;
            sec_mode_ff <= `RST_SEC_MODE;
            base_a_ff   <= `RST_BASE;
            base_b_ff   <= `RST_BASE;
            soft_rst_ff <= 1'b0;
        end else begin
            if (aw_take && !do_write) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            if (w_take && !do_write) begin
                w_held_ff  <= 1'b1;
                wdata_ff   <= s_axi_wdata;
                wstrb_ff   <= s_axi_wstrb;
                wready_ff  <= 1'b0;
            end
            soft_rst_ff <= soft_rst_req;
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                awready_ff <= 1'b0;
                wready_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= (wsel == 3'd0 || wsel == 3'd5) ? `RESP_SLVERR : `RESP_OKAY;
                if (wr_strb[0]) begin
                    case (wsel)
                        3'd1:    sel_a_ff    <= {3'b000, wr_data[4:0]};
                        3'd2:    sel_b_ff    <= {3'b000, wr_data[4:0]};
                        3'd3:    sec_mode_ff <= {7'h00, wr_data[`SEC_SHARE_BIT]};
                        3'd6:    base_a_ff[7:0] <= wr_data[7:0];
                        3'd7:    base_b_ff[7:0] <= wr_data[7:0];
                        default: sec_mode_ff <= sec_mode_ff;
                    endcase
                end
                if (wr_strb[1] && wsel == 3'd6)
                    base_a_ff[ADDR_W-1:8] <= wr_data[ADDR_W-1:8];
                if (wr_strb[1] && wsel == 3'd7)
                    base_b_ff[ADDR_W-1:8] <= wr_data[ADDR_W-1:8];
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
            // soft reset spares the mode register
            if (soft_rst_ff) begin
                sel_a_ff <= `RST_SEL_A;
                sel_b_ff <= `RST_SEL_B;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel.

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= (rsel == 3'd0) ? `RESP_SLVERR : `RESP_OKAY;
            case (rsel)
                3'd1:    rdata_ff <= {24'h00_0000, sel_a_ff};
                3'd2:    rdata_ff <= {24'h00_0000, sel_b_ff};
                3'd3:    rdata_ff <= {24'h00_0000, sec_mode_ff};
                3'd5:    rdata_ff <= {28'h000_0000, cs_a_n_ff, cs_b_n_ff,
                                      pri_oe_n_ff, sec_oe_n_ff};
                3'd6:    rdata_ff <= {{(32-ADDR_W){1'b0}}, base_a_ff};
                3'd7:    rdata_ff <= {{(32-ADDR_W){1'b0}}, base_b_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ISA side: synchronise pins, decode, register outputs.

    // Strobes are held in their idle state at reset so no select glitches out.
    wire rd_act = !ctl_s2_ff[1];
    wire wr_act = !ctl_s2_ff[2];
    wire hit_a  = sel_hit(sel_a_ff, base_a_ff, addr_s2_ff, ctl_s2_ff[0], rd_act, wr_act);
    wire hit_b  = sel_hit(sel_b_ff, base_b_ff, addr_s2_ff, ctl_s2_ff[0], rd_act, wr_act);
    wire share  = sec_mode_ff[`SEC_SHARE_BIT];
    wire cycle  = rd_act || wr_act;

    always @(posedge aclk) begin
        if (!aresetn) begin
            addr_s1_ff  <= {ADDR_W{1'b0}};
            addr_s2_ff  <= {ADDR_W{1'b0}};
            ctl_s1_ff   <= 3'b111;
            ctl_s2_ff   <= 3'b111;
            cs_a_n_ff   <= 1'b1;
            cs_b_n_ff   <= 1'b1;
            pri_oe_n_ff <= 1'b1;
            sec_oe_n_ff <= 1'b1;
        end else begin
            addr_s1_ff  <= isa_addr;
            addr_s2_ff  <= addr_s1_ff;
            ctl_s1_ff   <= {isa_iow_n, isa_ior_n, isa_aen};
            ctl_s2_ff   <= ctl_s1_ff;
            cs_a_n_ff   <= !hit_a;
            cs_b_n_ff   <= !hit_b;
            // primary buffers; shared when the share bit is set.
            pri_oe_n_ff <= !(cycle && (primary_port_active
                                       || (share && secondary_port_active)));
            // separate enable; left idle when shared.
            sec_oe_n_ff <= !(cycle && !share && secondary_port_active);
        end
    end

    assign s_axi_awready             = awready_ff;
    assign s_axi_wready              = wready_ff;
    assign s_axi_bvalid              = bvalid_ff;
    assign s_axi_bresp               = bresp_ff;
    assign s_axi_arready             = arready_ff;
    assign s_axi_rvalid              = rvalid_ff;
    assign s_axi_rdata               = rdata_ff;
    assign s_axi_rresp               = rresp_ff;
    assign primary_select_a_n        = cs_a_n_ff;
    assign primary_select_b_n        = cs_b_n_ff;
    assign primary_buffer_enable_n   = pri_oe_n_ff;
    assign secondary_buffer_enable_n = sec_oe_n_ff;

endmodule

/* ide_cs_props.sv */
// Purpose: Checker for the bus handshakes and decode outputs of the chip-select block.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Select outputs are judged only against idle pins, where no register state matters.
`timescale 1ns/1ns
module ide_cs_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire isa_aen,
    input wire isa_ior_n,
    input wire isa_iow_n,
    input wire primary_select_a_n,
    input wire primary_select_b_n,
    input wire primary_buffer_enable_n,
    input wire secondary_buffer_enable_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken during response");
    property p_rst_idle;
        $rose(aresetn) |-> primary_select_a_n && primary_select_b_n && !s_axi_bvalid;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
    property p_aen_off;
        isa_aen [*4] |=> primary_select_a_n && primary_select_b_n;
    endproperty
    a_aen_off: assert property (p_aen_off) else $error("select without address enable");
    property p_no_strobe;
        (isa_ior_n && isa_iow_n) [*4] |=> primary_buffer_enable_n && secondary_buffer_enable_n;
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("buffer enabled without strobe");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_sel_a: cover property (!primary_select_a_n);
endmodule
bind ide_chip_select_decode ide_cs_props u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n),
    .primary_select_a_n(primary_select_a_n), .primary_select_b_n(primary_select_b_n),
    .primary_buffer_enable_n(primary_buffer_enable_n),
    .secondary_buffer_enable_n(secondary_buffer_enable_n)
);

/* isa_host_model.sv */
// Purpose: ISA host model that runs I/O cycles into the drive decoders.
// Assumes: Shares aclk with the block; the bench commands each cycle.
// Notes:   A cycle stands four edges, one more than the select path needs, then goes idle.
`timescale 1ns/1ns
module isa_host_model (
    input  wire        aclk,
    output reg  [15:0] isa_addr,
    output reg         isa_aen,
    output reg         isa_ior_n,
    output reg         isa_iow_n
);
    initial begin
        isa_addr = 16'h0000;
        isa_aen = 1'b1;
        isa_ior_n = 1'b1;
        isa_iow_n = 1'b1;
    end
    task cycle(input [15:0] a, input en, input rd, input wr);
        begin
            @(posedge aclk);
            isa_addr <= a;
            isa_aen <= ~en;
            isa_ior_n <= ~rd;
            isa_iow_n <= ~wr;
            repeat (4) @(posedge aclk);
            // The bus returns to idle so selects do not linger across register writes.
            isa_aen <= 1'b1;
            isa_ior_n <= 1'b1;
            isa_iow_n <= 1'b1;
        end
    endtask
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the drive chip-select block.
// Assumes: AXI4-Lite master tasks; ISA cycles come from the host model.
// Notes:   Bases are left at reset except base B, which moves the mask windows.
`timescale 1ns/1ns
`include "ide_cs_defs.vh"
module tb;
    localparam [11:0] A_SEL_A = `WIN_PRIMARY + 12'd4 * `IDX_SEL_A;
    localparam [11:0] A_SEL_B = `WIN_PRIMARY + 12'd4 * `IDX_SEL_B;
    localparam [11:0] A_MODE = `WIN_SECONDARY + 12'd4 * `IDX_SEC_MODE;
    localparam [11:0] A_CTRL = `WIN_CONTROL + 12'd4 * `IDX_CTRL;
    localparam [11:0] A_BASE_B = `WIN_CONTROL + 12'd4 * `IDX_BASE_B;
    localparam [11:0] A_STATUS = `WIN_CONTROL + 12'd4 * `IDX_STATUS;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, primary_port_active, secondary_port_active;
    reg  [11:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rd_data;
    reg  [3:0]  s_axi_wstrb;
    reg  [1:0]  rd_resp;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] isa_addr;
    wire        isa_aen, isa_ior_n, isa_iow_n, primary_select_a_n, primary_select_b_n;
    wire        primary_buffer_enable_n, secondary_buffer_enable_n;
    integer     miscompares, check_count, m, k;
    ide_chip_select_decode dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n),
        .primary_port_active(primary_port_active),
        .secondary_port_active(secondary_port_active),
        .primary_select_a_n(primary_select_a_n), .primary_select_b_n(primary_select_b_n),
        .primary_buffer_enable_n(primary_buffer_enable_n),
        .secondary_buffer_enable_n(secondary_buffer_enable_n)
    );
    isa_host_model u_isa (
        .aclk(aclk), .isa_addr(isa_addr), .isa_aen(isa_aen),
        .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n)
    );
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Waits have no limit of their own; a hung handshake is ended by the watchdog.
    task axi_write(input [11:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!(s_axi_bvalid && s_axi_bready)) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            check("bresp", {30'd0, s_axi_bresp}, {30'd0, `RESP_OKAY});
        end
    endtask
    task axi_read(input [11:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!(s_axi_rvalid && s_axi_rready)) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
        end
    endtask
    task rd_chk(input [8*10-1:0] what, input [11:0] a, input [31:0] exp);
        begin
            axi_read(a);
            check("rresp", {30'd0, rd_resp}, {30'd0, `RESP_OKAY});
            check(what, rd_data, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task reset_values;
        begin
            rd_chk("sel_a", A_SEL_A, 32'h0000_000C);
            rd_chk("sel_b", A_SEL_B, 32'h0000_0000);
            rd_chk("mode", A_MODE, 32'h0000_0000);
        end
    endtask
    // Only mask codes 0 to 5 are ever written here.
    // legal codes only
    task mask_sweep;
        begin
            axi_write(A_BASE_B, 32'h0000_0100);
            for (m = 0; m < 6; m = m + 1) begin
                axi_write(A_SEL_B, {27'd0, m[2:0], 2'b00});
                u_isa.cycle(16'h0100 | ((16'h0001 << m) - 16'h0001), 1'b1, 1'b0, 1'b0);
                check("win_top", {31'd0, primary_select_b_n}, 32'h0000_0000);
                u_isa.cycle(16'h0100 + (16'h0001 << m), 1'b1, 1'b0, 1'b0);
                check("win_out", {31'd0, primary_select_b_n}, 32'h0000_0001);
            end
        end
    endtask
    task qual_sweep;
        begin
            for (m = 0; m < 4; m = m + 1) begin
                axi_write(A_SEL_A, {30'd0, m[1:0]});
                for (k = 0; k < 4; k = k + 1) begin
                    u_isa.cycle(16'h0000, k != 3, k == 1 || k == 3, k == 2);
                    check("qual", {31'd0, primary_select_a_n}, {31'd0, !(k != 3 && (m == 0
                        || (m[0] && k == 1) || (m[1] && k == 2)))});
                end
            end
        end
    endtask
    task buffer_steer;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                axi_write(A_MODE, {31'd0, k[1]});
                primary_port_active <= (k == 0);
                secondary_port_active <= (k == 1 || k == 2);
                u_isa.cycle(16'h0000, 1'b1, 1'b1, 1'b0);
                check("pri_oe", {31'd0, primary_buffer_enable_n}, {31'd0, !(k == 0 || k == 2)});
                check("sec_oe", {31'd0, secondary_buffer_enable_n}, {31'd0, k != 1});
            end
        end
    endtask
    task soft_reset;
        begin
            axi_write(A_SEL_A, 32'h0000_0014);
            axi_write(A_SEL_B, 32'h0000_0017);
            axi_write(A_MODE, 32'h0000_0001);
            axi_write(A_CTRL, 32'h0000_0001);
            rd_chk("sel_a", A_SEL_A, 32'h0000_000C);
            rd_chk("sel_b", A_SEL_B, 32'h0000_0000);
            rd_chk("mode", A_MODE, 32'h0000_0001);
            rd_chk("status", A_STATUS, 32'h0000_000F);
            axi_read(12'h3C8);
            check("unmapped", {30'd0, rd_resp}, {30'd0, `RESP_SLVERR});
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        finish_test;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'd0;
        {s_axi_rready, primary_port_active, secondary_port_active} = 3'd0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'd0;
        s_axi_wstrb = 4'hF;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        reset_values;
        mask_sweep;
        qual_sweep;
        buffer_steer;
        soft_reset;
        finish_test;
    end
endmodule
